// File: hw/jpm_pin_mode.v
// Test access port controller and shared test-pin steering
`timescale 1ns/10ps
`default_nettype none
`include "jpm_defines.vh"

// Function
// - Dedicated mode keeps test pins other than reset off user logic
// - Mode-select pin never becomes user I/O
// - Dedicated mode uses standard mode-select meaning
// - Unset option means flexible sharing mode
// - Controller advances on mode-select and clock only
// - Power-up puts controller in reset state
// - Flexible reset state: shared pins are user I/O, serial output pin user output only
// - Clock rise with select low enables test
// - Test-reset option makes reset pin a synchronised, synchronous reset
// - Without option reset pin is user I/O
// - Unused user reset pin is tristated
// - Power ramp keeps every pin high-impedance
// - Reset pin low holds controller reset
// - No reset option means reset inactive
module jpm_pin_mode
(
  input  wire        core_clk,
  input  wire        reset_n,
  input  wire        cfg_dedicated,
  input  wire        cfg_test_reset,
  input  wire        cfg_reset_pin_used,
  input  wire        power_good,
  input  wire        tms_in,
  input  wire        tck_in,
  input  wire        tdi_in,
  input  wire        trst_in,
  output wire        tdo_out,
  output wire        tdo_oe,
  output wire        tck_oe,
  output wire        tck_out,
  output wire        tdi_oe,
  output wire        tdi_out,
  output wire        trst_out,
  output wire        trst_oe,
  input  wire        user_tck_out,
  input  wire        user_tck_oe,
  input  wire        user_tdi_out,
  input  wire        user_tdi_oe,
  input  wire        user_tdo_out,
  input  wire        user_tdo_oe,
  input  wire        user_trst_out,
  input  wire        user_trst_oe,
  output reg         user_tck_in,
  output reg         user_tdi_in,
  output reg         user_tdo_in,
  output reg         user_trst_in,
  input  wire        scan_tdo,
  input  wire        scan_tdo_en,
  output reg         scan_tdi,
  output reg         boundary_scan_function,
  output reg         tap_shift_dr,
  output reg         tap_shift_ir,
  output reg         tap_capture,
  output reg         tap_update,
  output reg  [15:0] tap_state
);

  // Two-stage synchronisers for every pin that is read
  reg [1:0] tms_sync;
  reg [1:0] tck_sync;
  reg [1:0] tdi_sync;
  reg [1:0] trst_sync;
  reg [1:0] pwr_sync;
  reg       tck_prev;
  reg       tdo_reg;
  reg       tdo_en_reg;
  reg [15:0] next_state;

  wire tck_rise;
  wire tck_fall;
  wire trst_hold;
  wire pins_live;
  // Pins belong to test logic in dedicated mode or outside reset
  wire test_owns_pins;

  // One-hot state codes, bit number equals state number
  localparam [15:0] ST_RESET  = `JPM_ST_RESET;
  localparam [15:0] ST_IDLE   = `JPM_ST_IDLE;
  localparam [15:0] ST_SEL_DR = `JPM_ST_SEL_DR;
  localparam [15:0] ST_CAP_DR = `JPM_ST_CAP_DR;
  localparam [15:0] ST_SHF_DR = `JPM_ST_SHF_DR;
  localparam [15:0] ST_EX1_DR = `JPM_ST_EX1_DR;
  localparam [15:0] ST_PAU_DR = `JPM_ST_PAU_DR;
  localparam [15:0] ST_EX2_DR = `JPM_ST_EX2_DR;
  localparam [15:0] ST_UPD_DR = `JPM_ST_UPD_DR;
  localparam [15:0] ST_SEL_IR = `JPM_ST_SEL_IR;
  localparam [15:0] ST_CAP_IR = `JPM_ST_CAP_IR;
  localparam [15:0] ST_SHF_IR = `JPM_ST_SHF_IR;
  localparam [15:0] ST_EX1_IR = `JPM_ST_EX1_IR;
  localparam [15:0] ST_PAU_IR = `JPM_ST_PAU_IR;
  localparam [15:0] ST_EX2_IR = `JPM_ST_EX2_IR;
  localparam [15:0] ST_UPD_IR = `JPM_ST_UPD_IR;

  // Reset-state decode; pin steering and drive enable both need it
  function jpm_in_reset;
    input [15:0] st;
    begin
      jpm_in_reset = (st == ST_RESET);
    end
  endfunction

  // Capture decode for either register path
  function jpm_is_capture;
    input [15:0] st;
    begin
      jpm_is_capture = (st == ST_CAP_DR) | (st == ST_CAP_IR);
    end
  endfunction

  // Update decode for either register path
  function jpm_is_update;
    input [15:0] st;
    begin
      jpm_is_update = (st == ST_UPD_DR) | (st == ST_UPD_IR);
    end
  endfunction

  // Pin crossings into core_clk domain
  // Reset levels match idle pins: select and data high, clock low
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tms_sync  <= 2'h3;
      tck_sync  <= 2'h0;
      tdi_sync  <= 2'h3;
      trst_sync <= 2'h3;
      pwr_sync  <= 2'h0;
    end
    else
    begin
      tms_sync  <= {tms_sync[0], tms_in};
      tck_sync  <= {tck_sync[0], tck_in};
      tdi_sync  <= {tdi_sync[0], tdi_in};
      trst_sync <= {trst_sync[0], trst_in};
      pwr_sync  <= {pwr_sync[0], power_good};
    end
  end

  // Edge detect reads only the second stage
  // Clock stage resets low, so release gives no false rise
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      tck_prev <= 1'b0;
    else
      tck_prev <= tck_sync[1];
  end

  assign tck_rise = tck_sync[1] & ~tck_prev;
  assign tck_fall = ~tck_sync[1] & tck_prev;
  assign pins_live = pwr_sync[1];
  // dedicated option owns the pins at once
  // Flag alone lags one clock after reset release
  assign test_owns_pins = cfg_dedicated | boundary_scan_function;

  // reset pin acts only with the option set
  // low reset pin forces reset state
  // no option means reset stays released
  // Reset pin sampled through sync, so release lags by two clocks
  assign trst_hold = cfg_test_reset & ~trst_sync[1];

  always @*
  begin
    next_state = ST_RESET;
    case (tap_state)
      ST_RESET:  next_state = tms_sync[1] ? ST_RESET  : ST_IDLE;
      ST_IDLE:   next_state = tms_sync[1] ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: next_state = tms_sync[1] ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: next_state = tms_sync[1] ? ST_EX1_DR : ST_SHF_DR;
      ST_SHF_DR: next_state = tms_sync[1] ? ST_EX1_DR : ST_SHF_DR;
      ST_EX1_DR: next_state = tms_sync[1] ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: next_state = tms_sync[1] ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: next_state = tms_sync[1] ? ST_UPD_DR : ST_SHF_DR;
      ST_UPD_DR: next_state = tms_sync[1] ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: next_state = tms_sync[1] ? ST_RESET  : ST_CAP_IR;
      ST_CAP_IR: next_state = tms_sync[1] ? ST_EX1_IR : ST_SHF_IR;
      ST_SHF_IR: next_state = tms_sync[1] ? ST_EX1_IR : ST_SHF_IR;
      ST_EX1_IR: next_state = tms_sync[1] ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: next_state = tms_sync[1] ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: next_state = tms_sync[1] ? ST_UPD_IR : ST_SHF_IR;
      ST_UPD_IR: next_state = tms_sync[1] ? ST_SEL_DR : ST_IDLE;
      default:   next_state = ST_RESET;
    endcase
  end

  // power-up reset lands in reset state
  // advance only on clock rise, mode-select steers
  // Reset pin wins over a clock rise in the same cycle
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      tap_state <= `JPM_ST_RESET;
    else if (trst_hold)
      tap_state <= `JPM_ST_RESET;
    else if (tck_rise)
      tap_state <= next_state;
  end

  // test function in every state but reset
  // flexible reset state hands pins to user
  // dedicated option pins always test function
  // dedicated only when option set, else flexible
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      boundary_scan_function <= 1'b0;
    else
      boundary_scan_function <= cfg_dedicated | ~jpm_in_reset(tap_state);
  end

  // Decoded strobes for the scan chains, one cycle on a clock rise
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tap_shift_dr <= 1'b0;
      tap_shift_ir <= 1'b0;
      tap_capture  <= 1'b0;
      tap_update   <= 1'b0;
      scan_tdi     <= 1'b0;
    end
    else
    begin
      tap_shift_dr <= tck_rise & (tap_state == `JPM_ST_SHF_DR);
      tap_shift_ir <= tck_rise & (tap_state == `JPM_ST_SHF_IR);
      tap_capture  <= tck_rise & jpm_is_capture(tap_state);
      tap_update   <= tck_rise & jpm_is_update(tap_state);
      if (tck_rise)
        scan_tdi <= tdi_sync[1];
    end
  end

  // Serial output changes on the falling test clock, as the standard expects
  // Enable drops in reset state, so the user side can own the pin
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tdo_reg    <= 1'b0;
      tdo_en_reg <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_reg    <= scan_tdo;
      tdo_en_reg <= scan_tdo_en & ~jpm_in_reset(tap_state);
    end
  end

  // user gets only the reset pin in dedicated mode, when the test-reset option is off
  // Registered so user logic sees one clean clock domain
  // reset pin passed to user without option
  always @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      user_tck_in  <= 1'b0;
      user_tdi_in  <= 1'b0;
      user_tdo_in  <= 1'b0;
      user_trst_in <= 1'b0;
    end
    else
    begin
      user_tck_in  <= ~test_owns_pins & tck_sync[1];
      user_tdi_in  <= ~test_owns_pins & tdi_sync[1];
      user_tdo_in  <= 1'b0;
      user_trst_in <= ~cfg_test_reset & trst_sync[1];
    end
  end

  // nothing drives until power is good
  // mode-select pin has no output at all
  // Test clock and data input are inputs in test function
  // Power flag lags two clocks through its synchroniser
  assign tck_out  = user_tck_out;
  assign tck_oe   = pins_live & ~test_owns_pins & user_tck_oe;
  assign tdi_out  = user_tdi_out;
  assign tdi_oe   = pins_live & ~test_owns_pins & user_tdi_oe;
  assign tdo_out  = test_owns_pins ? tdo_reg : user_tdo_out;
  assign tdo_oe   = pins_live & (test_owns_pins ? tdo_en_reg : user_tdo_oe);

  // unused user reset pin stays tristated
  // user drives reset pin when option off
  // Option checked first, so a test reset pin never drives
  assign trst_out = user_trst_out;
  assign trst_oe  = pins_live & ~cfg_test_reset & cfg_reset_pin_used & user_trst_oe;

endmodule // jpm_pin_mode
`default_nettype wire

// File: hw/jpm_defines.vh
// Constants for the test-pin sharing block
`ifndef JPM_DEFINES_VH
`define JPM_DEFINES_VH

// Controller state codes, one-hot over sixteen bits
`define JPM_ST_RESET    16'h0001
`define JPM_ST_IDLE     16'h0002
`define JPM_ST_SEL_DR   16'h0004
`define JPM_ST_CAP_DR   16'h0008
`define JPM_ST_SHF_DR   16'h0010
`define JPM_ST_EX1_DR   16'h0020
`define JPM_ST_PAU_DR   16'h0040
`define JPM_ST_EX2_DR   16'h0080
`define JPM_ST_UPD_DR   16'h0100
`define JPM_ST_SEL_IR   16'h0200
`define JPM_ST_CAP_IR   16'h0400
`define JPM_ST_SHF_IR   16'h0800
`define JPM_ST_EX1_IR   16'h1000
`define JPM_ST_PAU_IR   16'h2000
`define JPM_ST_EX2_IR   16'h4000
`define JPM_ST_UPD_IR   16'h8000

// Number of core clocks a pin takes to cross into the core domain
`define JPM_SYNC_DEPTH  2

`endif

// File: verif/jpm_pin_mode_checker.sv
// Concurrent checks on the test-pin sharing block
`timescale 1ns/10ps
`default_nettype none
`include "jpm_defines.vh"
module jpm_pin_mode_checker
(
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        cfg_dedicated,
  input wire logic        cfg_test_reset,
  input wire logic        cfg_reset_pin_used,
  input wire logic        power_good,
  input wire logic        trst_in,
  input wire logic        tck_oe,
  input wire logic        tdi_oe,
  input wire logic        tdo_oe,
  input wire logic        trst_oe,
  input wire logic        user_tck_in,
  input wire logic        user_tdi_in,
  input wire logic        user_trst_in,
  input wire logic        boundary_scan_function,
  input wire logic        tap_capture,
  input wire logic        tap_update,
  input wire logic [15:0] tap_state
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Controller steps out of its reset state
  sequence s_leave;
    tap_state == `JPM_ST_RESET ##1 tap_state != `JPM_ST_RESET;
  endsequence
  // Reset pin low long enough to pass the synchroniser
  sequence s_trst_low;
    (cfg_test_reset && !trst_in) [*5];
  endsequence
  AST_DED_NO_USER:
    assert property (cfg_dedicated |-> !tck_oe && !tdi_oe && !user_tck_in && !user_tdi_in)
    else $error("user path open in dedicated mode");
  AST_PWRUP_RESET:
    assert property ($rose(reset_n) |-> tap_state == `JPM_ST_RESET)
    else $error("controller not in reset state after reset");
  AST_LEAVE_IDLE:
    assert property (s_leave |-> tap_state == `JPM_ST_IDLE)
    else $error("reset state left to a state other than idle");
  AST_TEST_FN:
    assert property (!cfg_dedicated |=> boundary_scan_function == ($past(tap_state) != 16'h0001))
    else $error("pin function does not follow controller state");
  AST_TEST_NO_OE:
    assert property (boundary_scan_function && !cfg_dedicated |-> !tck_oe && !tdi_oe)
    else $error("user drive on a pin in test function");
  AST_TRST_HOLD:
    assert property (s_trst_low |-> tap_state == `JPM_ST_RESET)
    else $error("controller left reset while reset pin low");
  AST_TRST_DED:
    assert property (cfg_test_reset |-> !trst_oe && !user_trst_in)
    else $error("reset pin used as user pin under test-reset option");
  AST_TRST_UNUSED:
    assert property (!cfg_reset_pin_used |-> !trst_oe)
    else $error("unused reset pin is driven");
  AST_PWR_Z:
    assert property (!power_good [*3] |-> !(tck_oe || tdi_oe || tdo_oe || trst_oe))
    else $error("pin driven while power not good");
  AST_ONE_HOT:
    assert property ($onehot(tap_state))
    else $error("controller state not one-hot");
  AST_DED_FN:
    assert property (cfg_dedicated |=> boundary_scan_function)
    else $error("pins not in test function in dedicated mode");
  AST_CAPTURE:
    assert property ($changed(tap_state) && tap_state != `JPM_ST_RESET &&
      ($past(tap_state) == `JPM_ST_CAP_DR || $past(tap_state) == `JPM_ST_CAP_IR)
      |-> tap_capture)
    else $error("capture strobe missing after capture state");
  AST_UPDATE:
    assert property ($changed(tap_state) && tap_state != `JPM_ST_RESET &&
      ($past(tap_state) == `JPM_ST_UPD_DR || $past(tap_state) == `JPM_ST_UPD_IR)
      |-> tap_update)
    else $error("update strobe missing after update state");
endmodule // jpm_pin_mode_checker
bind jpm_pin_mode jpm_pin_mode_checker chk_u (.*);
`default_nettype wire

// File: verif/jpm_tester_model.sv
// Behavioural external test controller on the test pins
`timescale 1ns/10ps
`default_nettype none
module jpm_tester_model
(
  input wire logic core_clk,
  output var logic tck,
  output var logic tms,
  output var logic tdi,
  output var logic trst
);
  // Clock stands low and select pulled high between frames
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst = 1'b1;
  end
  // One test clock; lo sets the low time, so slow tester too
  task automatic step(input logic m, input logic d, input int lo);
    tms <= m;
    tdi <= d;
    repeat (lo) @(negedge core_clk);
    tck <= 1'b1;
    repeat (13) @(negedge core_clk);
    tck <= 1'b0;
  endtask
  task automatic hold_reset(input logic v);
    trst <= v;
  endtask
endmodule // jpm_tester_model
`default_nettype wire

// File: verif/tb_top.sv
// Self-checking bench for the test-pin sharing block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic core_clk = 0, reset_n = 0, cfg_dedicated = 0, cfg_test_reset = 0;
  logic cfg_reset_pin_used = 1, power_good = 1, scan_tdo = 0, scan_tdo_en = 0;
  logic user_tck_out = 0, user_tck_oe = 0, user_tdi_out = 0, user_tdi_oe = 0;
  logic user_tdo_out = 0, user_tdo_oe = 0, user_trst_out = 0, user_trst_oe = 0;
  wire tms_in, tck_in, tdi_in, trst_in, tdo_out, tdo_oe, tck_oe, tck_out, tdi_oe, tdi_out;
  wire trst_out, trst_oe, user_tck_in, user_tdi_in, user_tdo_in, user_trst_in, scan_tdi;
  wire boundary_scan_function, tap_shift_dr, tap_shift_ir, tap_capture, tap_update;
  wire [15:0] tap_state;
  wire tck_m, tms_m, tdi_m, trst_m;
  logic [15:0] q_st[$], p_st;
  logic q_bs[$], p_bs;
  int fail_count = 0, n_compared = 0, cyc = 0, cur = 0;
  // State walk through all sixteen states, ending with five selects high
  int w_st[29] = '{1,2,3,4,5,6,7,8,2,9,10,11,12,13,14,15,1,2,9,0,1,2,3,4,5,8,2,9,0};
  bit w_m[29] = '{0,1,0,0,1,0,1,1,1,1,0,0,1,0,1,1,0,1,1,1,0,1,0,0,1,1,1,1,1};
  jpm_pin_mode dut_u (.*);
  jpm_tester_model tst_u (.core_clk(core_clk), .tck(tck_m), .tms(tms_m), .tdi(tdi_m),
                          .trst(trst_m));
  // Pin level comes from whichever party enables its driver
  assign tms_in = tms_m;
  assign tck_in = tck_oe ? tck_out : tck_m;
  assign tdi_in = tdi_oe ? tdi_out : tdi_m;
  assign trst_in = trst_oe ? trst_out : trst_m;
  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Options change only under reset, since they are static
  task automatic rst(input logic d, input logic t);
    reset_n = 0;
    cfg_dedicated = d;
    cfg_test_reset = t;
    cfg_reset_pin_used = d;
    repeat (2) @(negedge core_clk);
    reset_n = 1;
    cur = 0;
  endtask
  // Steps table entries, noting each expected state and each flexible-mode pin function change
  task automatic walk(input int a, input int b, input int lo);
    for (int i = a; i <= b; i++)
    begin
      q_st.push_back(16'h0001 << w_st[i]);
      if (!cfg_dedicated && (w_st[i] == 0) != (cur == 0))
        q_bs.push_back(w_st[i] != 0);
      cur = w_st[i];
      {user_tck_out, user_tdi_out, user_tdi_oe, user_tdo_out} = 4'($urandom);
      {user_tdo_oe, user_trst_out, user_trst_oe, scan_tdo, scan_tdo_en} = 5'($urandom);
      tst_u.step(w_m[i], 1'($urandom), lo);
    end
  endtask
  // Oldest note compared whenever state changes, or function changes in flexible mode
  always @(posedge core_clk)
  begin
    if (reset_n && tap_state !== p_st)
      chk("tap_state", tap_state, q_st.size() ? q_st.pop_front() : 16'hxxxx);
    if (reset_n && !cfg_dedicated && boundary_scan_function !== p_bs)
      chk("bs_fn", boundary_scan_function, q_bs.size() ? q_bs.pop_front() : 1'bx);
    p_st <= tap_state;
    p_bs <= boundary_scan_function;
    cyc++;
    if (cyc == 6000)
    begin
      fail_count++;
      wrap_up;
    end
  end
  initial
  begin
    void'($urandom(32'h9aab626f));
    rst(0, 0);
    // flexible default, reset pin no effect
    tst_u.hold_reset(0);
    walk(0, 28, 12);
    walk(20, 28, 40);
    // reset pin forces reset, clock edges ignored
    tst_u.hold_reset(1);
    rst(0, 1);
    walk(0, 3, 12);
    q_st.push_back(16'h0001);
    q_bs.push_back(1'b0);
    cur = 0;
    tst_u.hold_reset(0);
    tst_u.step(0, 0, 12);
    tst_u.hold_reset(1);
    walk(20, 28, 12);
    // dedicated pins, five selects high return to reset
    rst(1, 0);
    walk(0, 3, 12);
    walk(24, 28, 12);
    // drivers released while power is not good
    {user_tck_oe, user_tdi_oe, user_tdo_oe, user_trst_oe, scan_tdo_en} = 5'h1f;
    power_good = 0;
    repeat (10) @(negedge core_clk);
    chk("pins_off", {tck_oe, tdi_oe, tdo_oe, trst_oe}, 16'h0000);
    power_good = 1;
    repeat (10) @(negedge core_clk);
    chk("tck_oe", tck_oe, 16'h0000);
    chk("trst_oe", trst_oe, 16'h0001);
    chk("user_trst_in", user_trst_in, user_trst_out);
    chk("notes_left", q_st.size() + q_bs.size(), 16'h0000);
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire
